// File: design/acm_consts.vh
// constants for the analog compare / value monitor block
// assumes a 50 MHz scan-logic clock and an AXI4-Lite register port
// Functional notes
// - physical channels map 0..10 V linearly onto internal 0..1000
// - each comparator operand scaled separately: operand times gain plus offset
// - gain is signed hundredths, magnitude limited to 10.00
// - offset is signed integer, magnitude at most 10000, added after gain
// - difference is scaled first operand minus scaled second operand
// - set>=clear: high above set, low at/below clear, else hold
// - set<clear: high exactly while set <= difference < clear
// - decimal count never affects comparison; plain integer compare
// - comparator output depends only on scaled difference, thresholds and its held output
// - capture rising edge latches operand as reference, starts monitoring
// - monitor scales both captured reference and live operand
// - monitor high while capture high and live outside reference +/- band
// - monitor cleared when live back inside band or capture low
// - monitor decimal count only formats display, never arithmetic
`ifndef ACM_CONSTS_VH
`define ACM_CONSTS_VH

`define ACM_OP_W       16
`define ACM_GAIN_W     12
`define ACM_VAL_W      24
`define ACM_GAIN_ONE   100
`define ACM_GAIN_MAX   1000
`define ACM_OFS_MAX    10000
`define ACM_THR_MAX    20000
`define ACM_PHYS_SPAN  1000
`define ACM_ADC_W      12
`define ACM_ADC_FULL   4095
`define ACM_NCH        8
`define ACM_NMRK       6
`define ACM_CLK_MHZ    50
`define ACM_SCAN_US    100

`define ACM_AW         8
`define ACM_R_GAIN     8'h00
`define ACM_R_OFFSET   8'h04
`define ACM_R_SET_THR  8'h08
`define ACM_R_CLR_THR  8'h0c
`define ACM_R_BAND     8'h10
`define ACM_R_DECIMALS 8'h14
`define ACM_R_SOURCE   8'h18
`define ACM_R_STATUS   8'h1c
`define ACM_R_DIFF     8'h20
`define ACM_R_REF      8'h24
`define ACM_R_LIVE     8'h28
`define ACM_R_MARKER   8'h40

`define ACM_GAIN_RST   16'h0064
`define ACM_DEC_W      2

`define ACM_SRC_X_LSB  0
`define ACM_SRC_Y_LSB  8
`define ACM_SRC_M_LSB  16
`define ACM_SRC_W      23
`define ACM_SEL_PHYS   2'h0
`define ACM_SEL_MARK   2'h1
`define ACM_SEL_BLK    2'h2

`define ACM_ST_CMP     0
`define ACM_ST_MON     1
`define ACM_ST_ACT     2

`define ACM_RESP_OK    2'h0
`define ACM_RESP_ERR   2'h2

`endif

// File: design/acm_scale.v
// gain and offset scaling of one signed operand
// purely combinational; caller registers the result once per scan
`timescale 1ns/100ps
`include "acm_consts.vh"

module acm_scale #(
  parameter OP_W   = `ACM_OP_W,
  parameter GAIN_W = `ACM_GAIN_W,
  parameter VAL_W  = `ACM_VAL_W
) (
  input  wire signed [OP_W-1:0]   operand,
  input  wire signed [GAIN_W-1:0] gain,
  input  wire signed [OP_W-1:0]   offset,
  output wire signed [VAL_W-1:0]  scaled
);

  localparam PW = OP_W + GAIN_W;
  localparam signed [PW-1:0] ONE = `ACM_GAIN_ONE;

  // full-width product so 32767 * 10.00 cannot wrap
  wire signed [PW-1:0] prod = operand * gain;
  wire signed [PW-1:0] quot = prod / ONE;
  wire signed [VAL_W-1:0] ofs_x = {{(VAL_W-OP_W){offset[OP_W-1]}}, offset};

  assign scaled = quot[VAL_W-1:0] + ofs_x;

endmodule

// File: design/acm_thresh.v
// next output of the threshold comparator
// combinational; the caller holds the current output in a register
`timescale 1ns/100ps
`include "acm_consts.vh"

module acm_thresh #(
  parameter DW  = `ACM_VAL_W + 1,
  parameter TW  = `ACM_OP_W
) (
  input  wire signed [DW-1:0] diff,
  input  wire signed [TW-1:0] set_thr,
  input  wire signed [TW-1:0] clr_thr,
  input  wire                 q_cur,
  output reg                  q_next
);

  wire signed [DW-1:0] set_x = {{(DW-TW){set_thr[TW-1]}}, set_thr};
  wire signed [DW-1:0] clr_x = {{(DW-TW){clr_thr[TW-1]}}, clr_thr};

  // plain integer compare, no decimal point involved
  always @* begin
    q_next = q_cur;
    if (set_x >= clr_x) begin
      if (diff > set_x)
        q_next = 1'b1;
      else if (diff <= clr_x)
        q_next = 1'b0;
    end else begin
      q_next = (diff >= set_x) && (diff < clr_x);
    end
  end

endmodule

// File: design/acm_top.v
// analog differential comparator and value monitor with AXI4-Lite registers
// analog channel codes arrive asynchronously; block inputs and capture are
// driven by logic on CLK
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "acm_consts.vh"

module acm_top #(
  parameter SCAN_CYC = `ACM_SCAN_US * `ACM_CLK_MHZ,
  parameter ADC_FULL = `ACM_ADC_FULL
) (
  input  wire                                CLK,
  input  wire                                RST_N,
  input  wire [`ACM_AW-1:0]                  S_AXI_AWADDR,
  input  wire                                S_AXI_AWVALID,
  output wire                                S_AXI_AWREADY,
  input  wire [31:0]                         S_AXI_WDATA,
  input  wire [3:0]                          S_AXI_WSTRB,
  input  wire                                S_AXI_WVALID,
  output wire                                S_AXI_WREADY,
  output wire [1:0]                          S_AXI_BRESP,
  output wire                                S_AXI_BVALID,
  input  wire                                S_AXI_BREADY,
  input  wire [`ACM_AW-1:0]                  S_AXI_ARADDR,
  input  wire                                S_AXI_ARVALID,
  output wire                                S_AXI_ARREADY,
  output wire [31:0]                         S_AXI_RDATA,
  output wire [1:0]                          S_AXI_RRESP,
  output wire                                S_AXI_RVALID,
  input  wire                                S_AXI_RREADY,
  input  wire [`ACM_NCH*`ACM_ADC_W-1:0]      PHYS_CH,
  input  wire [`ACM_OP_W-1:0]                BLK_X,
  input  wire [`ACM_OP_W-1:0]                BLK_Y,
  input  wire [`ACM_OP_W-1:0]                BLK_M,
  input  wire                                MON_EN,
  output wire                                CMP_Q,
  output wire                                MON_Q
);

  localparam OW   = `ACM_OP_W;
  localparam VW   = `ACM_VAL_W;
  localparam DW   = `ACM_VAL_W + 1;
  localparam AW   = `ACM_AW;
  localparam CW   = `ACM_ADC_W;
  localparam CNTW = $clog2(SCAN_CYC + 1);
  localparam [31:0]     SCAN_LAST_W = SCAN_CYC - 1;
  localparam [CNTW-1:0] SCAN_LAST   = SCAN_LAST_W[CNTW-1:0];

  // ---------------- helpers ----------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // clamp a written word into [lo, hi]
  function [15:0] sat;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      if ($signed(v) > $signed(hi))
        sat = hi[15:0];
      else if ($signed(v) < $signed(lo))
        sat = lo[15:0];
      else
        sat = v[15:0];
    end
  endfunction

  // channel code to internal 0..1000 span
  function [OW-1:0] phys_scale;
    input [CW-1:0] code;
    reg   [31:0]   t;
    begin
      t = ({20'h0_0000, code} * `ACM_PHYS_SPAN) / ADC_FULL;
      phys_scale = t[OW-1:0];
    end
  endfunction

  // ---------------- registers ----------------
  reg [15:0]              gain_reg;
  reg [15:0]              offset_reg;
  reg [15:0]              set_thr_reg;
  reg [15:0]              clr_thr_reg;
  reg [15:0]              band_reg;
  reg [`ACM_DEC_W-1:0]    decimals_reg;
  reg [`ACM_SRC_W-1:0]    source_reg;
  reg [`ACM_NMRK*OW-1:0]  marker_reg;

  reg [`ACM_NCH*CW-1:0]   ch_meta_reg;
  reg [`ACM_NCH*CW-1:0]   ch_sync_reg;

  reg [CNTW-1:0]          scan_cnt_reg;
  reg signed [DW-1:0]     diff_reg;
  reg signed [VW-1:0]     ref_reg;
  reg signed [VW-1:0]     live_reg;
  reg                     cmp_q_reg;
  reg                     mon_q_reg;
  reg                     mon_act_reg;
  reg                     en_prev_reg;

  // operand source: physical channel, marker storage or block input
  function [OW-1:0] pick;
    input [1:0]    sel;
    input [2:0]    idx;
    input [OW-1:0] blk;
    begin
      case (sel)
        `ACM_SEL_PHYS: pick = phys_scale(ch_sync_reg[idx*CW +: CW]);
        `ACM_SEL_MARK: pick = (idx < `ACM_NMRK) ? marker_reg[idx*OW +: OW]
                                                : {OW{1'b0}};
        default:       pick = blk;
      endcase
    end
  endfunction

  function addr_ok;
    input [AW-1:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) &&
                ((a <= `ACM_R_LIVE) ||
                 ((a >= `ACM_R_MARKER) &&
                  (a < `ACM_R_MARKER + 4 * `ACM_NMRK)));
    end
  endfunction

  function [2:0] mrk_idx;
    input [AW-1:0] a;
    reg   [AW-1:0] d;
    begin
      d = a - `ACM_R_MARKER;
      mrk_idx = d[4:2];
    end
  endfunction

  function [31:0] sx16;
    input [15:0] v;
    begin
      sx16 = {{16{v[15]}}, v};
    end
  endfunction

  function [31:0] reg_read;
    input [AW-1:0] a;
    begin
      reg_read = 32'h0000_0000;
      if (a >= `ACM_R_MARKER)
        reg_read = sx16(marker_reg[mrk_idx(a)*OW +: OW]);
      else
        case (a)
          `ACM_R_GAIN:     reg_read = sx16(gain_reg);
          `ACM_R_OFFSET:   reg_read = sx16(offset_reg);
          `ACM_R_SET_THR:  reg_read = sx16(set_thr_reg);
          `ACM_R_CLR_THR:  reg_read = sx16(clr_thr_reg);
          `ACM_R_BAND:     reg_read = sx16(band_reg);
          `ACM_R_DECIMALS: reg_read[`ACM_DEC_W-1:0] = decimals_reg;
          `ACM_R_SOURCE:   reg_read[`ACM_SRC_W-1:0] = source_reg;
          `ACM_R_STATUS: begin
            reg_read[`ACM_ST_CMP] = cmp_q_reg;
            reg_read[`ACM_ST_MON] = mon_q_reg;
            reg_read[`ACM_ST_ACT] = mon_act_reg;
          end
          `ACM_R_DIFF:     reg_read = {{(32-DW){diff_reg[DW-1]}}, diff_reg};
          `ACM_R_REF:      reg_read = {{(32-VW){ref_reg[VW-1]}}, ref_reg};
          `ACM_R_LIVE:     reg_read = {{(32-VW){live_reg[VW-1]}}, live_reg};
          default:         reg_read = 32'h0000_0000;
        endcase
    end
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  reg [AW-1:0] aw_addr_reg;
  reg          aw_full_reg;
  reg [31:0]   w_data_reg;
  reg [3:0]    w_strb_reg;
  reg          w_full_reg;
  reg          bvalid_reg;
  reg [1:0]    bresp_reg;
  reg          rvalid_reg;
  reg [1:0]    rresp_reg;
  reg [31:0]   rdata_reg;

  assign S_AXI_AWREADY = !aw_full_reg;
  assign S_AXI_WREADY  = !w_full_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;

  // address and data may arrive in either order; write once both are held
  wire        do_wr   = aw_full_reg && w_full_reg && !bvalid_reg;
  wire        wr_ok   = addr_ok(aw_addr_reg);
  wire [31:0] wr_word = merge(reg_read(aw_addr_reg), w_data_reg, w_strb_reg);

  localparam [31:0] GMAX = `ACM_GAIN_MAX;
  localparam [31:0] OMAX = `ACM_OFS_MAX;
  localparam [31:0] TMAX = `ACM_THR_MAX;

  always @(posedge CLK) begin
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= {AW{1'b0}};
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `ACM_RESP_OK;
    end else begin
      if (S_AXI_AWVALID && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? `ACM_RESP_OK : `ACM_RESP_ERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // settings; gain, offset, threshold and band writes saturate to the legal limits
  always @(posedge CLK) begin
    if (!RST_N) begin
      gain_reg     <= `ACM_GAIN_RST;
      offset_reg   <= 16'h0000;
      set_thr_reg  <= 16'h0000;
      clr_thr_reg  <= 16'h0000;
      band_reg     <= 16'h0000;
      decimals_reg <= {`ACM_DEC_W{1'b0}};
      source_reg   <= {`ACM_SRC_W{1'b0}};
      marker_reg   <= {(`ACM_NMRK*OW){1'b0}};
    end else if (do_wr && wr_ok) begin
      if (aw_addr_reg >= `ACM_R_MARKER)
        marker_reg[mrk_idx(aw_addr_reg)*OW +: OW] <= wr_word[OW-1:0];
      else
        case (aw_addr_reg)
          `ACM_R_GAIN:     gain_reg    <= sat(wr_word, -GMAX, GMAX);
          `ACM_R_OFFSET:   offset_reg  <= sat(wr_word, -OMAX, OMAX);
          `ACM_R_SET_THR:  set_thr_reg <= sat(wr_word, -TMAX, TMAX);
          `ACM_R_CLR_THR:  clr_thr_reg <= sat(wr_word, -TMAX, TMAX);
          `ACM_R_BAND:     band_reg    <= sat(wr_word, 32'h0, TMAX);
          // only kept for display formatting elsewhere
          `ACM_R_DECIMALS: decimals_reg <= wr_word[`ACM_DEC_W-1:0];
          `ACM_R_SOURCE:   source_reg   <= wr_word[`ACM_SRC_W-1:0];
          default: ;
        endcase
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `ACM_RESP_OK;
      rdata_reg  <= 32'h0000_0000;
    end else if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_ok(S_AXI_ARADDR) ? `ACM_RESP_OK : `ACM_RESP_ERR;
      rdata_reg  <= addr_ok(S_AXI_ARADDR) ? reg_read(S_AXI_ARADDR) : 32'h0000_0000;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- channel synchroniser ----------------
  // codes are assumed slow-moving; a word may tear for one scan at most
  always @(posedge CLK) begin
    if (!RST_N) begin
      ch_meta_reg <= {(`ACM_NCH*CW){1'b0}};
      ch_sync_reg <= {(`ACM_NCH*CW){1'b0}};
    end else begin
      ch_meta_reg <= PHYS_CH;
      ch_sync_reg <= ch_meta_reg;
    end
  end

  // ---------------- operand selection and scaling ----------------
  wire [`ACM_SRC_W-1:0] src_x = source_reg >> `ACM_SRC_X_LSB;
  wire [`ACM_SRC_W-1:0] src_y = source_reg >> `ACM_SRC_Y_LSB;
  wire [`ACM_SRC_W-1:0] src_m = source_reg >> `ACM_SRC_M_LSB;

  wire [OW-1:0] first_analog_operand  = pick(src_x[1:0], src_x[6:4], BLK_X);
  wire [OW-1:0] second_analog_operand = pick(src_y[1:0], src_y[6:4], BLK_Y);
  wire [OW-1:0] mon_operand           = pick(src_m[1:0], src_m[6:4], BLK_M);

  wire signed [VW-1:0] x_scaled;
  wire signed [VW-1:0] y_scaled;
  wire signed [VW-1:0] m_scaled;

  acm_scale u_scale_x (
    .operand (first_analog_operand),
    .gain    (gain_reg[`ACM_GAIN_W-1:0]),
    .offset  (offset_reg),
    .scaled  (x_scaled)
  );

  acm_scale u_scale_y (
    .operand (second_analog_operand),
    .gain    (gain_reg[`ACM_GAIN_W-1:0]),
    .offset  (offset_reg),
    .scaled  (y_scaled)
  );

  // same shared gain and offset for the monitor
  acm_scale u_scale_m (
    .operand (mon_operand),
    .gain    (gain_reg[`ACM_GAIN_W-1:0]),
    .offset  (offset_reg),
    .scaled  (m_scaled)
  );

  // ---------------- comparator ----------------
  wire signed [DW-1:0] x_w  = {x_scaled[VW-1], x_scaled};
  wire signed [DW-1:0] y_w  = {y_scaled[VW-1], y_scaled};
  wire signed [DW-1:0] diff = x_w - y_w;
  wire                 cmp_next;

  acm_thresh u_thresh (
    .diff    (diff),
    .set_thr (set_thr_reg),
    .clr_thr (clr_thr_reg),
    .q_cur   (cmp_q_reg),
    .q_next  (cmp_next)
  );

  // ---------------- monitor band test ----------------
  wire signed [DW-1:0] ref_w  = {ref_reg[VW-1], ref_reg};
  wire signed [DW-1:0] live_w = {m_scaled[VW-1], m_scaled};
  wire signed [DW-1:0] band_w = {{(DW-16){1'b0}}, band_reg};
  wire                 outside = (live_w > ref_w + band_w) ||
                                 (live_w < ref_w - band_w);
  wire                 en_rise = MON_EN && !en_prev_reg;

  // ---------------- scan timing ----------------
  wire scan_tick = (scan_cnt_reg == SCAN_LAST);

  always @(posedge CLK) begin
    if (!RST_N)
      scan_cnt_reg <= {CNTW{1'b0}};
    else if (scan_tick)
      scan_cnt_reg <= {CNTW{1'b0}};
    else
      scan_cnt_reg <= scan_cnt_reg + 1'b1;
  end

  // both functions evaluate together, once per scan
  always @(posedge CLK) begin
    if (!RST_N) begin
      diff_reg    <= {DW{1'b0}};
      ref_reg     <= {VW{1'b0}};
      live_reg    <= {VW{1'b0}};
      cmp_q_reg   <= 1'b0;
      mon_q_reg   <= 1'b0;
      mon_act_reg <= 1'b0;
      en_prev_reg <= 1'b0;
    end else if (scan_tick) begin
      diff_reg    <= diff;
      live_reg    <= m_scaled;
      cmp_q_reg   <= cmp_next;
      en_prev_reg <= MON_EN;
      if (!MON_EN) begin
        mon_q_reg   <= 1'b0;
        mon_act_reg <= 1'b0;
      end else if (en_rise) begin
        // fresh reference equals the live value, so never outside yet
        ref_reg     <= m_scaled;
        mon_act_reg <= 1'b1;
        mon_q_reg   <= 1'b0;
      end else begin
        mon_q_reg <= mon_act_reg && outside;
      end
    end
  end

  assign CMP_Q = cmp_q_reg;
  assign MON_Q = mon_q_reg;

endmodule

// File: bench/acm_asserts.sv
// checker for the compare / monitor top: output pacing and register-port handshakes
// assumes one clock domain, reset synchronous active low, bound to acm_top
`timescale 1ns/100ps

module acm_asserts #(
  parameter int SCAN_CYC = 5000
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_WVALID,
  input wire logic       S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic       S_AXI_RVALID,
  input wire logic       S_AXI_RREADY,
  input wire logic       MON_EN,
  input wire logic       CMP_Q,
  input wire logic       MON_Q
);
  localparam int HOLD = SCAN_CYC - 1;
  logic [15:0] cmp_age_reg;
  logic [15:0] mon_age_reg;
  logic [15:0] en_low_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ages saturate so a long idle never wraps into a false fail
  always @(posedge CLK) begin
    if (!RST_N) begin
      cmp_age_reg <= HOLD[15:0];
      mon_age_reg <= HOLD[15:0];
      en_low_reg  <= 16'h0;
    end else begin
      cmp_age_reg <= $changed(CMP_Q) ? 16'h0 : (cmp_age_reg < HOLD ? cmp_age_reg + 1'b1 : cmp_age_reg);
      mon_age_reg <= $changed(MON_Q) ? 16'h0 : (mon_age_reg < HOLD ? mon_age_reg + 1'b1 : mon_age_reg);
      en_low_reg  <= MON_EN ? 16'h0 : (en_low_reg <= SCAN_CYC ? en_low_reg + 1'b1 : en_low_reg);
    end
  end

  property p_cmp_hold; $changed(CMP_Q) |-> cmp_age_reg >= HOLD; endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("comparator output moved inside a scan");
  property p_mon_hold; $changed(MON_Q) |-> mon_age_reg >= HOLD; endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("monitor output moved inside a scan");
  property p_mon_off; en_low_reg > SCAN_CYC |-> !MON_Q; endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor output high with capture low");
  property p_mon_rise; $rose(MON_Q) |-> $past(MON_EN); endproperty
  a_mon_rise: assert property (p_mon_rise) else $error("monitor output rose without capture");
  property p_b_after;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_after; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");

  c_cmp_set: cover property ($rose(CMP_Q));
  c_mon_set: cover property ($rose(MON_Q));
  c_wr_err:  cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule

bind acm_top acm_asserts #(.SCAN_CYC(SCAN_CYC)) i_chk (
  .CLK(CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .MON_EN(MON_EN), .CMP_Q(CMP_Q), .MON_Q(MON_Q));

// File: bench/acm_src_model.sv
// far-side sources: eight channel codes and three block operands
// assumes the bench sets the wanted values; all change on the rising edge
`timescale 1ns/100ps

module acm_src_model (
  input  wire logic        clk,
  input  wire logic [15:0] x_val,
  input  wire logic [15:0] y_val,
  input  wire logic [15:0] m_val,
  input  wire logic [11:0] code,
  output logic      [95:0] phys_ch = '0,
  output logic      [15:0] blk_x = '0,
  output logic      [15:0] blk_y = '0,
  output logic      [15:0] blk_m = '0
);
  // unused channels carry distinct codes so a wrong index shows up
  always @(posedge clk) begin
    for (int n = 1; n < 8; n++) begin
      phys_ch[12*n +: 12] <= 12'(n * 12'h111);
    end
    phys_ch[11:0] <= code;
    blk_x <= x_val;
    blk_y <= y_val;
    blk_m <= m_val;
  end
endmodule

// File: bench/tb.sv
// self-checking bench: register accesses, comparator table, physical source, monitor
// assumes acm_top with a short scan and the source model on the operand inputs
`timescale 1ns/100ps
`include "acm_consts.vh"

module tb;
  localparam int SCAN = 8;
  localparam int WAITC = 2 * SCAN + 4;
  logic CLK = 0, RST_N = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [15:0] sx = 0, sy = 0, sm = 0;
  logic [11:0] scode = 0;
  logic mon_en = 0;
  wire aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, cmp_q, mon_q;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [95:0] phys;
  wire [15:0] bx, by, bm;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  int tset[8] = '{100, 100, 100, 100, 20, 20, 20, 20};
  int tclr[8] = '{20, 20, 20, 20, 100, 100, 100, 100};
  int tx[8] = '{100, 70, 50, 90, 50, 90, 49, 70};
  logic tq[8] = '{1, 1, 0, 0, 1, 0, 0, 1};
  int tm[4] = '{60, 61, 40, 39};
  logic tmq[4] = '{0, 1, 0, 1};

  always #10 CLK = ~CLK;

  acm_src_model i_src (.clk(CLK), .x_val(sx), .y_val(sy), .m_val(sm), .code(scode),
    .phys_ch(phys), .blk_x(bx), .blk_y(by), .blk_m(bm));
  acm_top #(.SCAN_CYC(SCAN)) i_dut (.CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PHYS_CH(phys), .BLK_X(bx), .BLK_Y(by), .BLK_M(bm), .MON_EN(mon_en),
    .CMP_Q(cmp_q), .MON_Q(mon_q));

  task report_and_stop;
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge CLK);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!done) begin
      @(posedge CLK);
      if (awvalid && aw_rdy) awvalid <= 1'b0;
      if (wvalid && w_rdy) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1;
        chk("bresp", 32'(bresp), 32'(er));
      end
    end
  endtask

  task axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic done;
    done = 0;
    @(posedge CLK);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(posedge CLK);
      if (arvalid && ar_rdy) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done = 1;
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
      end
    end
  endtask

  task scans;
    repeat (WAITC) @(posedge CLK);
  endtask

  // cuts a hang short
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    axi_rd(`ACM_R_GAIN, `ACM_RESP_OK, rd);
    chk("gain_rst", rd, 32'h64);
    axi_rd(`ACM_R_STATUS, `ACM_RESP_OK, rd);
    chk("status_rst", rd, 32'h0);
    axi_rd(8'h2c, `ACM_RESP_ERR, rd);
    chk("unmapped", rd, 32'h0);
    axi_wr(8'h2c, 32'h1, `ACM_RESP_ERR);
    axi_wr(`ACM_R_GAIN, 32'h1000, `ACM_RESP_OK);
    axi_rd(`ACM_R_GAIN, `ACM_RESP_OK, rd);
    chk("gain_max", rd, 32'h3e8);
    axi_wr(`ACM_R_GAIN, 32'hfffff000, `ACM_RESP_OK);
    axi_rd(`ACM_R_GAIN, `ACM_RESP_OK, rd);
    chk("gain_min", rd, 32'hfffffc18);
    axi_wr(`ACM_R_OFFSET, 32'd30000, `ACM_RESP_OK);
    axi_rd(`ACM_R_OFFSET, `ACM_RESP_OK, rd);
    chk("offset_max", rd, 32'h2710);
    // both operands from blocks; equal offsets cancel in the difference
    axi_wr(`ACM_R_SOURCE, 32'h00020202, `ACM_RESP_OK);
    axi_wr(`ACM_R_GAIN, 32'hc8, `ACM_RESP_OK);
    axi_wr(`ACM_R_OFFSET, 32'h7, `ACM_RESP_OK);
    sy <= 16'd40;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) axi_wr(`ACM_R_DECIMALS, 32'h3, `ACM_RESP_OK);
      axi_wr(`ACM_R_SET_THR, 32'(tset[i]), `ACM_RESP_OK);
      axi_wr(`ACM_R_CLR_THR, 32'(tclr[i]), `ACM_RESP_OK);
      sx <= 16'(tx[i]);
      scans();
      chk("cmp_q", 32'(cmp_q), 32'(tq[i]));
      axi_rd(`ACM_R_DIFF, `ACM_RESP_OK, rd);
      chk("diff", rd, 32'(2 * tx[i] - 80));
    end
    // negative product truncates toward zero
    axi_wr(`ACM_R_GAIN, 32'hffffff6a, `ACM_RESP_OK);
    sx <= 16'd3;
    sy <= 16'd0;
    scans();
    axi_rd(`ACM_R_DIFF, `ACM_RESP_OK, rd);
    chk("diff_neg", rd, 32'hfffffffc);
    axi_wr(`ACM_R_SOURCE, 32'h00000200, `ACM_RESP_OK);
    axi_wr(`ACM_R_GAIN, 32'h64, `ACM_RESP_OK);
    axi_wr(`ACM_R_OFFSET, 32'h0, `ACM_RESP_OK);
    scode <= 12'hfff;
    scans();
    axi_rd(`ACM_R_LIVE, `ACM_RESP_OK, rd);
    chk("live_full", rd, 32'd1000);
    scode <= 12'h800;
    scans();
    axi_rd(`ACM_R_LIVE, `ACM_RESP_OK, rd);
    chk("live_mid", rd, 32'd500);
    axi_wr(`ACM_R_SOURCE, 32'h00020202, `ACM_RESP_OK);
    axi_wr(`ACM_R_GAIN, 32'hc8, `ACM_RESP_OK);
    axi_wr(`ACM_R_OFFSET, 32'h5, `ACM_RESP_OK);
    axi_wr(`ACM_R_BAND, 32'd20, `ACM_RESP_OK);
    sm <= 16'd50;
    scans();
    mon_en <= 1'b1;
    scans();
    axi_rd(`ACM_R_REF, `ACM_RESP_OK, rd);
    chk("ref", rd, 32'd105);
    chk("mon_first", 32'(mon_q), 32'h0);
    for (int i = 0; i < 4; i++) begin
      sm <= 16'(tm[i]);
      scans();
      chk("mon_q", 32'(mon_q), 32'(tmq[i]));
    end
    mon_en <= 1'b0;
    scans();
    chk("mon_off", 32'(mon_q), 32'h0);
    report_and_stop();
  end
endmodule
